// [src/tov_vote.sv]
// Shared constants and the per-point vote for the triple output voter
package tov_pkg;
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned LINK_TMO_US   = 40;
    localparam int unsigned LINK_TMO_CYC  = (LINK_TMO_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned TMO_W         = 16;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] DUPDEF_OFF = 8'h04;
    localparam logic [7:0] DFLT_OFF   = 8'h08;
    localparam logic [7:0] STAT_OFF   = 8'h0C;
    localparam logic [7:0] VOTED_OFF  = 8'h10;
    localparam logic [7:0] DISC_A_OFF = 8'h14;
    localparam logic [7:0] DISC_B_OFF = 8'h18;
    localparam logic [7:0] DISC_C_OFF = 8'h1C;
    localparam logic [7:0] TMO_OFF    = 8'h20;
    // Control and status fields
    localparam int unsigned CTRL_FORCE_BIT = 0;
    localparam int unsigned CTRL_RAPID_BIT = 1;
    localparam int unsigned STAT_ADM_LSB   = 3;
    // Reset values and response codes
    localparam logic [1:0]  CTRL_RST   = 2'h2;
    localparam logic [31:0] DUPDEF_RST = 32'h0;
    localparam logic [31:0] DFLT_RST   = 32'h0;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLV   = 2'h2;

    // Two of three majority per bit
    function automatic logic [31:0] tov_maj3(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
        return (a & b) | (a & c) | (b & c);
    endfunction
endpackage

`timescale 1ns/100ps
// Combinational vote over the controllers currently taking part
module tov_vote #(
    parameter int unsigned NPTS = 16
) (
    input  wire logic [NPTS-1:0] cmd_a_i,
    input  wire logic [NPTS-1:0] cmd_b_i,
    input  wire logic [NPTS-1:0] cmd_c_i,
    input  wire logic [2:0]      use_i,
    input  wire logic [NPTS-1:0] dup_i,
    input  wire logic [NPTS-1:0] dflt_i,
    output logic      [NPTS-1:0] vote_o
);
    import tov_pkg::*;

    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [31:0] d;
    assign a = 32'(cmd_a_i);
    assign b = 32'(cmd_b_i);
    assign c = 32'(cmd_c_i);
    assign d = 32'(dup_i);

    // Duplex default stands in for the one missing controller
    always_comb begin
        unique case (use_i)
            3'h7: vote_o = NPTS'(tov_maj3(a, b, c));
            3'h3: vote_o = NPTS'(tov_maj3(a, b, d));
            3'h5: vote_o = NPTS'(tov_maj3(a, d, c));
            3'h6: vote_o = NPTS'(tov_maj3(d, b, c));
            3'h1: vote_o = cmd_a_i;
            3'h2: vote_o = cmd_b_i;
            3'h4: vote_o = cmd_c_i;
            3'h0: vote_o = dflt_i;
        endcase
    end
endmodule

// [src/tov_top.sv]
// Triple output voter with logon control, discrepancy report and AXI4-Lite registers
//
// Notes on behaviour
// - Three online: majority vote, ignore duplex default
// - Two online: duplex default replaces missing vote
// - Duplex default one: output is OR
// - Duplex default zero: output is AND
// - One online: follow that controller
// - Returning controller waits until it agrees
// - Force logon bit admits returning controller
// - Interrogation answered with per-point discrepancy report
// - No controller online: outputs to default
`timescale 1ns/100ps
module tov_top
    import tov_pkg::*;
#(
    parameter int unsigned NPTS     = 16,
    parameter int unsigned TMO_INIT = tov_pkg::LINK_TMO_CYC
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              ce_i,
    // Controller side
    input  wire logic [2:0]        ctl_valid_i,
    input  wire logic [3*NPTS-1:0] ctl_data_i,
    input  wire logic [2:0]        ctl_query_i,
    // Field side and report
    output logic      [NPTS-1:0]   out_o,
    output logic      [2:0]        online_o,
    output logic      [2:0]        admitted_o,
    output logic                   rapid_discrepancy_report_enable_o,
    output logic                   report_valid_o,
    output logic      [2:0]        report_to_o,
    output logic      [3*NPTS-1:0] report_disc_o,
    // AXI4-Lite
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    import tov_pkg::*;

    logic [NPTS-1:0]  cmd_q [3];
    logic [TMO_W-1:0] tmo_cnt [3];
    logic [2:0]       online;
    logic [2:0]       adm;
    logic [NPTS-1:0]  voted;
    logic [NPTS-1:0]  disc [3];
    logic             force_logon_bit;
    logic             rapid_en;
    logic [NPTS-1:0]  dup_def;
    logic [NPTS-1:0]  dflt;
    logic [TMO_W-1:0] tmo_lim;
    logic [7:0]       aw_addr;
    logic             aw_have;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             w_have;
    logic             wr_go;
    logic             wr_hit;
    logic [31:0]      rd_val;
    logic             rd_hit;

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int k = 0; k < 4; k++) begin
            if (be[k]) begin
                r[8*k +: 8] = nw[8*k +: 8];
            end
        end
        return r;
    endfunction

    // Vote over admitted controllers only
    tov_vote #(
        .NPTS (NPTS)
    ) u_vote (
        .cmd_a_i (cmd_q[0]),
        .cmd_b_i (cmd_q[1]),
        .cmd_c_i (cmd_q[2]),
        .use_i   (adm),
        .dup_i   (dup_def),
        .dflt_i  (dflt),
        .vote_o  (voted)
    );

    // Last command from each controller
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 3; i++) begin
                cmd_q[i] <= '0;
            end
        end else if (ce_i) begin
            for (int i = 0; i < 3; i++) begin
                if (ctl_valid_i[i]) begin
                    cmd_q[i] <= ctl_data_i[i*NPTS +: NPTS];
                end
            end
        end
    end

    // Online flags; silence for tmo_lim cycles drops a controller
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            online <= '0;
            for (int i = 0; i < 3; i++) begin
                tmo_cnt[i] <= '0;
            end
        end else if (ce_i) begin
            for (int i = 0; i < 3; i++) begin
                if (ctl_valid_i[i]) begin
                    online[i]  <= 1'b1;
                    tmo_cnt[i] <= '0;
                end else if (online[i]) begin
                    if (tmo_cnt[i] + 1'b1 >= tmo_lim) begin
                        online[i] <= 1'b0;
                    end else begin
                        tmo_cnt[i] <= tmo_cnt[i] + 1'b1;
                    end
                end
            end
        end
    end

    // Logon: a returning controller must agree first so tripped outputs stay tripped
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            adm <= '0;
        end else if (ce_i) begin
            for (int i = 0; i < 3; i++) begin
                if (!online[i]) begin
                    adm[i] <= 1'b0;
                end else if (!adm[i]) begin
                    if (force_logon_bit) begin
                        adm[i] <= 1'b1;
                    end else if (ctl_valid_i[i] && (adm == 3'h0 || ctl_data_i[i*NPTS +: NPTS] == out_o)) begin
                        adm[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // Outputs, status and per-point disagreement of admitted controllers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_o      <= '0;
            online_o   <= '0;
            admitted_o <= '0;
            for (int i = 0; i < 3; i++) begin
                disc[i] <= '0;
            end
        end else if (ce_i) begin
            out_o      <= voted;
            online_o   <= online;
            admitted_o <= adm;
            for (int i = 0; i < 3; i++) begin
                disc[i] <= adm[i] ? (cmd_q[i] ^ voted) : '0;
            end
        end
    end

    // Discrepancy report on interrogation; all askers in one cycle share the answer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            report_valid_o <= 1'b0;
            report_to_o    <= '0;
            report_disc_o  <= '0;
        end else if (ce_i) begin
            report_valid_o <= |ctl_query_i;
            report_to_o    <= ctl_query_i;
            if (|ctl_query_i) begin
                report_disc_o <= {disc[2], disc[1], disc[0]};
            end
        end
    end

    // AXI write channel capture, either order
    assign wr_go = aw_have && w_have && !s_axi_bvalid;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLV;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_have       <= 1'b0;
                w_have        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Writable registers; status words are read only and answer OKAY
    always_comb begin
        unique case (aw_addr)
            CTRL_OFF, DUPDEF_OFF, DFLT_OFF, TMO_OFF, STAT_OFF, VOTED_OFF,
            DISC_A_OFF, DISC_B_OFF, DISC_C_OFF: wr_hit = 1'b1;
            default:                            wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            force_logon_bit <= CTRL_RST[CTRL_FORCE_BIT];
            rapid_en        <= CTRL_RST[CTRL_RAPID_BIT];
            dup_def         <= NPTS'(DUPDEF_RST);
            dflt            <= NPTS'(DFLT_RST);
            tmo_lim         <= TMO_W'(TMO_INIT);
        end else if (ce_i && wr_go) begin
            unique case (aw_addr)
                CTRL_OFF: begin
                    if (w_strb[0]) begin
                        force_logon_bit <= w_data[CTRL_FORCE_BIT];
                        rapid_en        <= w_data[CTRL_RAPID_BIT];
                    end
                end
                DUPDEF_OFF: dup_def <= NPTS'(merge_be(32'(dup_def), w_data, w_strb));
                DFLT_OFF:   dflt <= NPTS'(merge_be(32'(dflt), w_data, w_strb));
                TMO_OFF:    tmo_lim <= TMO_W'(merge_be(32'(tmo_lim), w_data, w_strb));
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rapid_discrepancy_report_enable_o <= 1'b0;
        end else if (ce_i) begin
            rapid_discrepancy_report_enable_o <= rapid_en;
        end
    end

    // Read decode
    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            CTRL_OFF:   rd_val = {30'h0, rapid_en, force_logon_bit};
            DUPDEF_OFF: rd_val = 32'(dup_def);
            DFLT_OFF:   rd_val = 32'(dflt);
            STAT_OFF:   rd_val = {26'h0, adm, online};
            VOTED_OFF:  rd_val = 32'(out_o);
            DISC_A_OFF: rd_val = 32'(disc[0]);
            DISC_B_OFF: rd_val = 32'(disc[1]);
            DISC_C_OFF: rd_val = 32'(disc[2]);
            TMO_OFF:    rd_val = 32'(tmo_lim);
            default:    rd_hit = 1'b0;
        endcase
    end

    // Read channel: one cycle from address to data
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_val;
                s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLV;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Helper terms for checks
    logic [NPTS-1:0] act_or;
    logic [NPTS-1:0] act_and;
    logic [NPTS-1:0] maj_all;
    logic [1:0]      n_adm;
    assign act_or  = (adm[0] ? cmd_q[0] : '0) | (adm[1] ? cmd_q[1] : '0) | (adm[2] ? cmd_q[2] : '0);
    assign act_and = (adm[0] ? cmd_q[0] : '1) & (adm[1] ? cmd_q[1] : '1) & (adm[2] ? cmd_q[2] : '1);
    assign maj_all = NPTS'(tov_maj3(32'(cmd_q[0]), 32'(cmd_q[1]), 32'(cmd_q[2])));
    assign n_adm   = 2'(adm[0]) + 2'(adm[1]) + 2'(adm[2]);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence two_up_s;
        ce_i && n_adm == 2'd2;
    endsequence

    triple_vote_a: assert property (ce_i && adm == 3'h7 |=> out_o == $past(maj_all))
        else $error("three-way vote wrong");
    duplex_sub_a: assert property (two_up_s |=> out_o == (($past(dup_def) & $past(act_or)) | (~$past(dup_def) & $past(act_and))))
        else $error("duplex substitute vote wrong");
    dup_one_a: assert property (two_up_s ##0 (dup_def == '1) |=> out_o == $past(act_or))
        else $error("duplex one not OR");
    dup_zero_a: assert property (two_up_s ##0 (dup_def == '0) |=> out_o == $past(act_and))
        else $error("duplex zero not AND");
    single_follow_a: assert property (ce_i && n_adm == 2'd1 |=> out_o == $past(act_or))
        else $error("single controller not followed");
    none_default_a: assert property (ce_i && adm == 3'h0 |=> out_o == $past(dflt))
        else $error("outputs not at default");
    query_report_a: assert property (ce_i && |ctl_query_i |=> report_valid_o && report_to_o == $past(ctl_query_i))
        else $error("interrogation not answered");

    for (genvar g = 0; g < 3; g++) begin : g_chk
        logon_hold_a: assert property (ce_i && online[g] && !adm[g] && !force_logon_bit && adm != 3'h0
            && ctl_valid_i[g] && ctl_data_i[g*NPTS +: NPTS] != out_o |=> !adm[g])
            else $error("disagreeing controller admitted");
        force_logon_a: assert property (ce_i && online[g] && force_logon_bit |=> adm[g])
            else $error("forced logon not taken");
        silence_drop_a: assert property (ce_i && online[g] && !ctl_valid_i[g]
            && tmo_cnt[g] + 1'b1 >= tmo_lim |=> !online[g] ##1 !adm[g])
            else $error("silent controller still online");
    end
endmodule

// [verif/tov_ctl_model.sv]
// Behavioural model of the three redundant controllers on the far side
`timescale 1ns/100ps
module tov_ctl_model #(
    parameter int unsigned NPTS = 16
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [2:0]        alive_i,
    input  wire logic [3*NPTS-1:0] word_i,
    input  wire logic [2:0]        ask_i,
    output logic      [2:0]        ctl_valid_o,
    output logic      [3*NPTS-1:0] ctl_data_o,
    output logic      [2:0]        ctl_query_o
);
    logic [3:0]        cnt;
    logic [3*NPTS-1:0] last;
    logic [2:0]        chg;
    logic [2:0]        next_valid;

    // A controller resends when its command word changes
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            chg[i] = word_i[i*NPTS +: NPTS] != last[i*NPTS +: NPTS];
        end
        next_valid = alive_i & ({3{cnt == 4'h0}} | chg);
    end

    // Periodic output messages keep each live controller online
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt         <= 4'h0;
            last        <= '0;
            ctl_valid_o <= 3'h0;
            ctl_data_o  <= '0;
            ctl_query_o <= 3'h0;
        end else begin
            cnt         <= cnt + 4'h1;
            last        <= word_i;
            ctl_valid_o <= next_valid;
            // Idle data lines toggle so stale words are never reused
            ctl_data_o  <= (|next_valid) ? word_i : ~ctl_data_o;
            ctl_query_o <= ask_i;
        end
    end
endmodule

// [verif/triple_output_voter_tb.sv]
// Self-checking bench for the triple output voter
`timescale 1ns/100ps
module triple_output_voter_tb;
    import tov_pkg::*;
    localparam int unsigned NP = 16;
    logic clk_i = 1'b0, rst_n_i = 1'b0;
    logic [2:0] alive = 3'h0, ask = 3'h0, valid, query, online, adm, rep_to;
    logic [NP-1:0] wa = '0, wb = '0, wc = '0, out;
    logic [3*NP-1:0] data, disc;
    logic rapid, rep_v, awr, wr, bv, arr, rv;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic [1:0] bresp, rresp, r;
    logic [31:0] d;
    logic [NP-1:0] v;
    int failures = 0, total_checks = 0;

    always #20 clk_i = ~clk_i;

    tov_ctl_model #(.NPTS(NP)) i_ctl (.clk_i(clk_i), .rst_n_i(rst_n_i), .alive_i(alive),
        .word_i({wc, wb, wa}), .ask_i(ask), .ctl_valid_o(valid), .ctl_data_o(data), .ctl_query_o(query));

    tov_top #(.NPTS(NP), .TMO_INIT(64)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .ctl_valid_i(valid), .ctl_data_i(data), .ctl_query_i(query), .out_o(out), .online_o(online),
        .admitted_o(adm), .rapid_discrepancy_report_enable_o(rapid), .report_valid_o(rep_v),
        .report_to_o(rep_to), .report_disc_o(disc), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready));

    task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
            failures++;
        end
    endtask

    task automatic test_done();
        $display("Checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic lost(input string name);
        chk(name, 48'h0, 48'h1);
        test_done();
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] resp);
        int n;
        @(posedge clk_i);
        awaddr <= a; wdata <= wd; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (bv === 1'b1) break;
        end
        if (n == 50) lost("axi write");
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] resp);
        int n;
        @(posedge clk_i);
        araddr <= a; arv <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (arv && arr) arv <= 1'b0;
            if (rv === 1'b1) break;
        end
        if (n == 50) lost("axi read");
        rd = rdata; resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Reset values and two unmapped addresses
    task automatic t_reset();
        chk("out after reset", out, 48'h0);
        axr(CTRL_OFF, d, r); chk("ctrl reset", d, {30'h0, CTRL_RST});
        axr(TMO_OFF, d, r); chk("timeout reg", d, 48'd64);
        axr(8'h40, d, r); chk("unmapped resp", r, RESP_SLV);
        chk("unmapped data", d, 48'h0);
        axw(8'h44, 32'hFFFF, r); chk("unmapped wresp", r, RESP_SLV);
    endtask

    // Logon of a returning controller only on agreement
    // Admission needs a message after the one that brings a controller online, so wait past one resend period
    task automatic t_logon();
        wa <= 16'h1234; alive <= 3'b001; settle(20);
        chk("lone out", out, 48'h1234);
        chk("first admitted", adm, 48'h1);
        wb <= 16'h00FF; alive <= 3'b011; settle(20);
        chk("disagree admitted", adm, 48'h1);
        chk("disagree out", out, 48'h1234);
        wb <= 16'h1234; settle(20);
        chk("agree admitted", adm, 48'h3);
        wc <= 16'h1234; alive <= 3'b111; settle(20);
        chk("three admitted", adm, 48'h7);
        chk("three online", online, 48'h7);
    endtask

    // Majority of three with the duplex default set against it
    task automatic t_vote3();
        axw(DUPDEF_OFF, 32'hFFFF, r);
        wa <= 16'hF0F0; wb <= 16'hCCCC; wc <= 16'hAAAA; settle(8);
        v = (16'hF0F0 & 16'hCCCC) | (16'hF0F0 & 16'hAAAA) | (16'hCCCC & 16'hAAAA);
        chk("majority", out, v);
    endtask

    // Interrogation by controller b, retried while the outputs move
    task automatic t_query();
        int n;
        int att;
        logic [NP-1:0] o0;
        logic [2:0] flog;
        for (att = 0; att < 3; att++) begin
            o0 = out;
            @(posedge clk_i); ask <= 3'b010;
            @(posedge clk_i); ask <= 3'b000;
            for (n = 0; n < 10; n++) begin
                @(posedge clk_i);
                if (rep_v === 1'b1) break;
            end
            if (n == 10) lost("report");
            if (out === o0) break;
        end
        chk("check retries", 48'(att), 48'h0);
        chk("report to", rep_to, 48'h2);
        chk("report disc", disc, {16'hAAAA ^ v, 16'hCCCC ^ v, 16'hF0F0 ^ v});
        // Fault log: one flag per controller that sent discrepant data
        flog = {|disc[47:32], |disc[31:16], |disc[15:0]};
        chk("fault log", flog, 48'h7);
        @(posedge clk_i); chk("report pulse", rep_v, 48'h0);
    endtask

    // Two online: low byte defaults to one, high byte to zero
    task automatic t_vote2();
        axw(DUPDEF_OFF, 32'h00FF, r);
        alive <= 3'b011; settle(120);
        chk("two online", online, 48'h3);
        v = (16'hF0F0 & 16'hCCCC) | ((16'hF0F0 | 16'hCCCC) & 16'h00FF);
        chk("duplex out", out, v);
        axr(VOTED_OFF, d, r); chk("voted reg", d, v);
        alive <= 3'b001; settle(120);
        chk("single out", out, 48'hF0F0);
    endtask

    // Force logon admits a disagreeing controller
    task automatic t_force();
        wc <= 16'h0000; alive <= 3'b101; settle(8);
        chk("c held out", adm, 48'h1);
        axw(CTRL_OFF, 32'h3, r); settle(6);
        chk("forced admit", adm, 48'h5);
        chk("mixed duplex", out, 48'h00F0);
        chk("rapid enable", rapid, 48'h1);
        axw(CTRL_OFF, 32'h0, r); settle(3);
        chk("rapid off", rapid, 48'h0);
        // Duplex default all ones with two voting: output is the OR
        axw(DUPDEF_OFF, 32'hFFFF, r); settle(3);
        chk("duplex one out", out, 48'hF0F0);
    endtask

    // Nobody online: outputs take the configured default
    task automatic t_none();
        axw(DFLT_OFF, 32'h5A5A, r);
        alive <= 3'b000; settle(120);
        chk("none online", online, 48'h0);
        chk("default out", out, 48'h5A5A);
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_logon();
        t_vote3();
        t_query();
        t_vote2();
        t_force();
        t_none();
        test_done();
    end
endmodule
